// ===== lmc_pkg.sv
package lmc_pkg;

  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_LED_CURRENT      = 8'h10;
  localparam logic [7:0] ADDR_LED_CONTROL      = 8'h11;
  localparam logic [7:0] ADDR_LED_CONFIGURATION = 8'h12;
  localparam logic [7:0] ADDR_NVM_WRITE_UNLOCK = 8'h13;

  localparam logic [7:0] RST_LED_CURRENT       = 8'h00;
  localparam logic [7:0] RST_LED_CONTROL       = 8'h00;
  localparam logic [7:0] RST_NVM_WRITE_UNLOCK  = 8'h00;
  localparam logic [7:0] RDATA_ZERO            = 8'h00;
  localparam logic [7:0] RDATA_PENDING         = 8'h01;

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int unsigned TORCH_CUR_LSB  = 0;
  localparam int unsigned TORCH_DUTY_LSB = 3;
  localparam int unsigned INDICATOR_CUR_LSB   = 6;
  localparam int unsigned BIT_INDICATOR_ON    = 0;
  localparam int unsigned BIT_INDICATOR_PULSE = 1;
  localparam int unsigned BIT_MOD_EN     = 2;
  localparam int unsigned BIT_TORCH_ON   = 3;
  localparam int unsigned CEILING_LSB    = 0;
  localparam int unsigned BIT_INDICATOR_PRESENT = 7;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam longint unsigned CLK_HZ       = 100_000_000;
  localparam longint unsigned PWM_FREQ_MHZ = 31_250_000; // 31.25 kHz in mHz
  localparam int unsigned PWM_SLOTS        = 32;
  localparam int unsigned PWM_PERIOD_CYC   =
    int'((CLK_HZ * 1000) / PWM_FREQ_MHZ);
  localparam int unsigned SLOT_CYC         = PWM_PERIOD_CYC / PWM_SLOTS;
  localparam logic [6:0]  SLOT_LAST        = 7'(SLOT_CYC - 1);
  localparam logic [4:0]  SLOT_IDX_LAST    = 5'(PWM_SLOTS - 1);
  localparam longint unsigned PULSE_MS     = 100;
  localparam int unsigned PULSE_CYC        = int'((CLK_HZ / 1000) * PULSE_MS);

  // arbitrary value, not a real unlock code
  localparam logic [7:0] UNLOCK_CODE_DEFAULT = 8'h5A;

  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lmc_bus_req_t;

  typedef enum logic [1:0] {
    UNL_LOCKED = 2'b00,
    UNL_ARMED  = 2'b01,
    UNL_OPEN   = 2'b11
  } lmc_unlock_t;

endpackage

// ===== lmc_led_ctrl.sv
// Function
// - modulator runs at fixed 31.25 kHz
// - indicator on, not present: torch output modulated
// - indicator on, present: indicator output used
// - pulse bit, not present: 100ms torch pulse
// - pulse bit, present: 100ms indicator pulse
// - pulse bit clears itself after pulse
// - steady indicator beats pulse request
// - modulation enable gates duty on torch
// - torch bit switches torch output
// - ceiling field read-only from nonvolatile memory
// - present bit writable, reset from memory
// - fault detection only when indicator present
// - right code unlocks memory one command
// - unlock register reads write pending
// - wrong code keeps memory locked
// - torch current clamped to ceiling
// - indicator current codes 2 to 16 mA
// - torch current codes 10 to 80 mA
module lmc_led_ctrl #(
  parameter int unsigned PULSE_LEN_CYC = lmc_pkg::PULSE_CYC,
  parameter logic [7:0]  UNLOCK_CODE   = lmc_pkg::UNLOCK_CODE_DEFAULT
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // register access, one decoded bus command
  input  wire lmc_pkg::lmc_bus_req_t bus_req_i,
  input  wire logic                 cmd_end_i,
  output logic [7:0]                rdata_o,
  // nonvolatile settings
  input  wire logic [2:0]           nvm_ceiling_i,
  input  wire logic                 nvm_present_i,
  output logic                      nvm_write_en_o,
  // torch output
  output logic                      torch_en_o,
  output logic [2:0]                torch_level_o,
  // indicator output
  output logic                      indicator_en_o,
  output logic [1:0]                indicator_level_o,
  output logic                      indicator_fault_det_en_o
);
  import lmc_pkg::*;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [5:0] duty_slots(input logic [2:0] sel);
    logic [5:0] n;
    n = 6'h01;
    unique case (sel)
      3'h0: n = 6'h01;
      3'h1: n = 6'h02;
      3'h2: n = 6'h03;
      3'h3: n = 6'h05;
      3'h4: n = 6'h08;
      3'h5: n = 6'h0C;
      3'h6: n = 6'h14;
      3'h7: n = 6'h20;
    endcase
    return n;
  endfunction

  function automatic logic [2:0] clamp3(input logic [2:0] v,
                                        input logic [2:0] lim);
    return (v > lim) ? lim : v;
  endfunction

  function automatic logic hit(input lmc_bus_req_t r, input logic [7:0] a);
    return r.addr == a;
  endfunction

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [2:0]  torch_current_sel_ff;
  logic [2:0]  torch_duty_sel_ff;
  logic [1:0]  indicator_current_sel_ff;
  logic        indicator_on_ff;
  logic        indicator_pulse_ff;
  logic        mod_en_ff;
  logic        torch_on_ff;
  logic [2:0]  torch_current_ceiling_ff;
  logic        indicator_present_ff;
  logic        nvm_loaded_ff;
  lmc_unlock_t unlock_ff;
  lmc_unlock_t nxt_unlock;
  logic [6:0]  slot_cnt_ff;
  logic [4:0]  slot_idx_ff;
  logic        pwm_hi_ff;
  logic [23:0] pulse_cnt_ff;
  logic        pulse_done;
  logic        wr_cur;
  logic        wr_ctl;
  logic        wr_cfg;
  logic        wr_unl;

  assign wr_cur = bus_req_i.wr && hit(bus_req_i, ADDR_LED_CURRENT);
  assign wr_ctl = bus_req_i.wr && hit(bus_req_i, ADDR_LED_CONTROL);
  assign wr_cfg = bus_req_i.wr && hit(bus_req_i, ADDR_LED_CONFIGURATION);
  assign wr_unl = bus_req_i.wr && hit(bus_req_i, ADDR_NVM_WRITE_UNLOCK);

  // -----------------------------------------------------------------
  // current register
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      torch_current_sel_ff     <= RST_LED_CURRENT[2:0];
      torch_duty_sel_ff        <= RST_LED_CURRENT[5:3];
      indicator_current_sel_ff <= RST_LED_CURRENT[7:6];
    end else if (wr_cur) begin
      torch_current_sel_ff     <= bus_req_i.wdata[TORCH_CUR_LSB +: 3];
      torch_duty_sel_ff        <= bus_req_i.wdata[TORCH_DUTY_LSB +: 3];
      indicator_current_sel_ff <= bus_req_i.wdata[INDICATOR_CUR_LSB +: 2];
    end
  end

  // -----------------------------------------------------------------
  // control register
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      indicator_on_ff <= RST_LED_CONTROL[BIT_INDICATOR_ON];
      mod_en_ff       <= RST_LED_CONTROL[BIT_MOD_EN];
      torch_on_ff     <= RST_LED_CONTROL[BIT_TORCH_ON];
    end else if (wr_ctl) begin
      indicator_on_ff <= bus_req_i.wdata[BIT_INDICATOR_ON];
      mod_en_ff       <= bus_req_i.wdata[BIT_MOD_EN];
      torch_on_ff     <= bus_req_i.wdata[BIT_TORCH_ON];
    end
  end

  // host write wins over the self clear in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      indicator_pulse_ff <= RST_LED_CONTROL[BIT_INDICATOR_PULSE];
    end else if (wr_ctl) begin
      indicator_pulse_ff <= bus_req_i.wdata[BIT_INDICATOR_PULSE];
    end else if (pulse_done) begin
      indicator_pulse_ff <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // configuration register, loaded from memory after reset
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      nvm_loaded_ff <= 1'b0;
    end else begin
      nvm_loaded_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      torch_current_ceiling_ff <= 3'h0;
    end else begin
      torch_current_ceiling_ff <= nvm_ceiling_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      indicator_present_ff <= 1'b0;
    end else if (!nvm_loaded_ff) begin
      indicator_present_ff <= nvm_present_i;
    end else if (wr_cfg) begin
      indicator_present_ff <= bus_req_i.wdata[BIT_INDICATOR_PRESENT];
    end
  end

  // -----------------------------------------------------------------
  // memory write unlock
  // -----------------------------------------------------------------
  always_comb begin
    nxt_unlock = unlock_ff;
    if (wr_unl) begin
      if (bus_req_i.wdata == UNLOCK_CODE) begin
        nxt_unlock = UNL_ARMED;
      end else begin
        nxt_unlock = UNL_LOCKED;
      end
    end else if (cmd_end_i) begin
      unique case (unlock_ff)
        UNL_LOCKED: nxt_unlock = UNL_LOCKED;
        UNL_ARMED:  nxt_unlock = UNL_OPEN;
        UNL_OPEN:   nxt_unlock = UNL_LOCKED;
        default:    nxt_unlock = UNL_LOCKED;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      unlock_ff <= UNL_LOCKED;
    end else begin
      unlock_ff <= nxt_unlock;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      nvm_write_en_o <= 1'b0;
    end else begin
      nvm_write_en_o <= (nxt_unlock == UNL_OPEN);
    end
  end

  // -----------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= RDATA_ZERO;
    end else if (bus_req_i.rd) begin
      unique case (bus_req_i.addr)
        ADDR_LED_CURRENT: rdata_o <= {indicator_current_sel_ff,
                                      torch_duty_sel_ff,
                                      torch_current_sel_ff};
        ADDR_LED_CONTROL: rdata_o <= {4'h0, torch_on_ff, mod_en_ff,
                                      indicator_pulse_ff,
                                      indicator_on_ff};
        ADDR_LED_CONFIGURATION: rdata_o <= {indicator_present_ff, 4'h0,
                                            torch_current_ceiling_ff};
        ADDR_NVM_WRITE_UNLOCK: rdata_o <= (unlock_ff == UNL_LOCKED) ?
                                          RDATA_ZERO : RDATA_PENDING;
        default: rdata_o <= RDATA_ZERO;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // duty-cycle generator
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      slot_cnt_ff <= 7'h00;
    end else if (slot_cnt_ff == SLOT_LAST) begin
      slot_cnt_ff <= 7'h00;
    end else begin
      slot_cnt_ff <= slot_cnt_ff + 7'h01;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      slot_idx_ff <= 5'h00;
    end else if (slot_cnt_ff == SLOT_LAST) begin
      slot_idx_ff <= (slot_idx_ff == SLOT_IDX_LAST) ? 5'h00
                                                    : slot_idx_ff + 5'h01;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_hi_ff <= 1'b0;
    end else begin
      pwm_hi_ff <= {1'b0, slot_idx_ff} < duty_slots(torch_duty_sel_ff);
    end
  end

  // -----------------------------------------------------------------
  // single indicator pulse timer
  // -----------------------------------------------------------------
  // a steady indicator holds the pulse pending; it runs once steady clears
  logic pulse_run;
  assign pulse_run = indicator_pulse_ff && !indicator_on_ff;

  assign pulse_done = pulse_run &&
                      (pulse_cnt_ff == 24'(PULSE_LEN_CYC - 1));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_cnt_ff <= 24'h000000;
    end else if (!pulse_run || pulse_done) begin
      pulse_cnt_ff <= 24'h000000;
    end else begin
      pulse_cnt_ff <= pulse_cnt_ff + 24'h000001;
    end
  end

  // -----------------------------------------------------------------
  // output routing
  // -----------------------------------------------------------------
  logic indicator_req;
  assign indicator_req = indicator_on_ff || indicator_pulse_ff;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      torch_level_o <= 3'h0;
    end else begin
      torch_level_o <= clamp3(torch_current_sel_ff,
                              torch_current_ceiling_ff);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      indicator_level_o <= 2'h0;
    end else begin
      indicator_level_o <= indicator_current_sel_ff;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      indicator_en_o <= 1'b0;
    end else begin
      indicator_en_o <= indicator_req && indicator_present_ff;
    end
  end

  // the torch request wins at torch_en_o if the host breaks the exclusion; indicator_en_o still follows the indicator request
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      torch_en_o <= 1'b0;
    end else if (torch_on_ff) begin
      torch_en_o <= !mod_en_ff || pwm_hi_ff;
    end else begin
      torch_en_o <= indicator_req && !indicator_present_ff &&
                    pwm_hi_ff;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      indicator_fault_det_en_o <= 1'b0;
    end else begin
      indicator_fault_det_en_o <= indicator_present_ff;
    end
  end

endmodule

// ===== lmc_led_ctrl_sva.sv
module lmc_led_ctrl_sva import lmc_pkg::*; #(
  parameter logic [7:0] UNLOCK_CODE = UNLOCK_CODE_DEFAULT
) (
  // clock and reset
  input wire logic         clk_i,
  input wire logic         rst_i,
  // register access
  input wire lmc_bus_req_t bus_req_i,
  input wire logic         cmd_end_i,
  input wire logic [7:0]   rdata_o,
  // settings and outputs
  input wire logic [2:0]   nvm_ceiling_i,
  input wire logic         nvm_write_en_o,
  input wire logic         torch_en_o,
  input wire logic [2:0]   torch_level_o,
  input wire logic         indicator_en_o,
  input wire logic         indicator_fault_det_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rd_ok;
  assign rd_ok = bus_req_i.rd;
  a_level_clamp: assert property ($stable(nvm_ceiling_i)[*3] |->
    torch_level_o <= nvm_ceiling_i) else $error("torch level above ceiling");
  a_indicator_fault_en: assert property (indicator_en_o |->
    indicator_fault_det_en_o) else $error("fault detect off");
  a_indicator_excl: assert property (indicator_en_o |-> !torch_en_o)
    else $error("torch on with indicator");
  a_unl_rise: assert property ($rose(nvm_write_en_o) |->
    $past(cmd_end_i)) else $error("unlock opened off boundary");
  a_unl_drop: assert property (nvm_write_en_o && cmd_end_i |=>
    !nvm_write_en_o) else $error("unlock held past command");
  a_bad_code: assert property (bus_req_i.wr &&
    bus_req_i.addr == ADDR_NVM_WRITE_UNLOCK &&
    bus_req_i.wdata != UNLOCK_CODE |=> !nvm_write_en_o)
    else $error("wrong code unlocked");
  a_unmapped_rd: assert property (rd_ok &&
    bus_req_i.addr[7:2] != 6'h04 |=> rdata_o == RDATA_ZERO)
    else $error("unmapped read not zero");
  a_ctrl_rsvd: assert property (rd_ok &&
    bus_req_i.addr == ADDR_LED_CONTROL |=> rdata_o[7:4] == 4'h0)
    else $error("control reserved bits set");
  a_cfg_read: assert property (rd_ok &&
    bus_req_i.addr == ADDR_LED_CONFIGURATION |=>
    rdata_o[6:0] == {4'h0, $past(nvm_ceiling_i, 2)})
    else $error("config read");
  a_unl_read: assert property (rd_ok &&
    bus_req_i.addr == ADDR_NVM_WRITE_UNLOCK |=> rdata_o[7:1] == 7'h00)
    else $error("unlock read wide");
  c_unlock: cover property ($rose(nvm_write_en_o));
  c_indicator: cover property ($rose(indicator_en_o));
  c_torch: cover property ($fell(torch_en_o));
endmodule

bind lmc_led_ctrl lmc_led_ctrl_sva #(.UNLOCK_CODE(UNLOCK_CODE))
  i_lmc_led_ctrl_sva (.clk_i, .rst_i, .bus_req_i, .cmd_end_i, .rdata_o,
  .nvm_ceiling_i, .nvm_write_en_o, .torch_en_o, .torch_level_o,
  .indicator_en_o, .indicator_fault_det_en_o);

// ===== lmc_host_model.sv
module lmc_host_model import lmc_pkg::*; (
  // clock
  input  wire logic   clk_i,
  // decoded bus command
  output lmc_bus_req_t bus_req_o,
  output logic         cmd_end_o,
  input  wire logic [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bus_req_o = '0;
    cmd_end_o = 1'b0;
  end
  // one cycle request, then idle fields show the inverse
  task automatic req(input logic w, input logic [7:0] a, d);
    @(negedge clk_i);
    bus_req_o = '{w, !w, a, d};
    @(negedge clk_i);
    bus_req_o = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == ADDR_LED_CONTROL && d[3]) d[1:0] = 2'b00;
    req(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req(1'b0, a, 8'h00);
    @(negedge clk_i);
    d = rdata_i;
  endtask
  task automatic fin();
    @(negedge clk_i);
    cmd_end_o = 1'b1;
    @(negedge clk_i);
    cmd_end_o = 1'b0;
  endtask
endmodule

// ===== tb_lmc_led_ctrl.sv
module tb_lmc_led_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import lmc_pkg::*;
  localparam int unsigned PLEN = 50;
  logic         clk_i  = 1'b0;
  logic         rst_i  = 1'b1;
  logic [2:0]   ceil_i = 3'h5;
  logic         pres_i = 1'b0;
  lmc_bus_req_t req;
  logic         cmd_end, nvm_we, t_en, i_en, f_en;
  logic [7:0]   rdata;
  logic [2:0]   t_lvl;
  logic [1:0]   i_lvl;
  int           failures = 0;
  int           compares = 0;
  always #5 clk_i = ~clk_i;
  lmc_led_ctrl #(.PULSE_LEN_CYC(PLEN)) i_lmc_led_ctrl (.clk_i, .rst_i,
    .bus_req_i(req), .cmd_end_i(cmd_end), .rdata_o(rdata),
    .nvm_ceiling_i(ceil_i), .nvm_present_i(pres_i), .nvm_write_en_o(nvm_we),
    .torch_en_o(t_en), .torch_level_o(t_lvl), .indicator_en_o(i_en),
    .indicator_level_o(i_lvl), .indicator_fault_det_en_o(f_en));
  lmc_host_model i_lmc_host_model (.clk_i, .bus_req_o(req),
    .cmd_end_o(cmd_end), .rdata_i(rdata));
  task automatic check(input logic [31:0] s, e, input string m);
    compares++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t %s seen %0h exp %0h", $time, m, s, e);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    i_lmc_host_model.wr(a, d);
  endtask
  task automatic rreg(input logic [7:0] a, e);
    logic [7:0] v;
    i_lmc_host_model.rd(a, v);
    check(v, e, "read");
  endtask
  task automatic highs(input int n, output int c, r);
    logic p;
    c = 0;
    r = 0;
    p = t_en;
    repeat (n) begin
      @(negedge clk_i);
      c += int'(t_en);
      r += int'(t_en && !p);
      p = t_en;
    end
  endtask
  task automatic t_regs();
    rreg(ADDR_LED_CONTROL, RST_LED_CONTROL);
    rreg(ADDR_LED_CONFIGURATION, {5'h00, ceil_i});
    rreg(ADDR_NVM_WRITE_UNLOCK, RST_NVM_WRITE_UNLOCK);
    rreg(8'h2A, RDATA_ZERO);
    wr(ADDR_LED_CONTROL, 8'hF0);
    rreg(ADDR_LED_CONTROL, 8'h00);
    wr(ADDR_LED_CONFIGURATION, 8'hFA);
    rreg(ADDR_LED_CONFIGURATION, {5'h10, ceil_i});
    $display("test regs done");
  endtask
  task automatic t_duty();
    int n[8] = '{1, 2, 3, 5, 8, 12, 20, 32};
    int c, r;
    wr(ADDR_LED_CONTROL, 8'h0C);
    for (int d = 0; d < 8; d++) begin
      wr(ADDR_LED_CURRENT, {2'b00, d[2:0], 3'h7});
      highs(3200, c, r);
      highs(3200, c, r);
      check(c, n[d] * 100, "duty");
      if (d < 7) check(r, 1, "period");
      check(t_lvl, 3'h5, "clamp");
    end
    wr(ADDR_LED_CURRENT, 8'h03);
    wr(ADDR_LED_CONTROL, 8'h08);
    highs(3200, c, r);
    check(c, 3200, "steady");
    check(t_lvl, 3'h3, "unclamped");
    wr(ADDR_LED_CONTROL, 8'h00);
    highs(100, c, r);
    check(c, 0, "off");
    $display("test duty done");
  endtask
  task automatic t_indicator();
    int c, r;
    wr(ADDR_LED_CURRENT, 8'hD7);
    wr(ADDR_LED_CONTROL, 8'h01);
    highs(3200, c, r);
    check(c, 0, "indicator no torch");
    check({i_en, i_lvl, f_en}, 4'hF, "indicator");
    wr(ADDR_LED_CONFIGURATION, 8'h00);
    highs(3200, c, r);
    highs(3200, c, r);
    check(c, 300, "indicator torch");
    check({i_en, f_en}, 2'b00, "indicator off");
    wr(ADDR_LED_CONTROL, 8'h00);
    $display("test indicator done");
  endtask
  task automatic t_pulse();
    int c;
    wr(ADDR_LED_CURRENT, 8'h3F);
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_LED_CONFIGURATION, {p[0], 7'h00});
      wr(ADDR_LED_CONTROL, 8'h02);
      c = 0;
      repeat (4 * PLEN) begin
        @(negedge clk_i);
        c += int'(p ? i_en : t_en);
      end
      check(c > PLEN - 3 && c < PLEN + 3, 1, "pulse");
      rreg(ADDR_LED_CONTROL, 8'h00);
    end
    wr(ADDR_LED_CONTROL, 8'h03);
    repeat (3 * PLEN) @(negedge clk_i);
    check(i_en, 1, "steady wins");
    rreg(ADDR_LED_CONTROL, 8'h03);
    wr(ADDR_LED_CONTROL, 8'h00);
    $display("test pulse done");
  endtask
  task automatic t_unlock();
    wr(ADDR_NVM_WRITE_UNLOCK, ~UNLOCK_CODE_DEFAULT);
    i_lmc_host_model.fin();
    rreg(ADDR_NVM_WRITE_UNLOCK, RDATA_ZERO);
    check(nvm_we, 0, "locked");
    i_lmc_host_model.fin();
    wr(ADDR_NVM_WRITE_UNLOCK, UNLOCK_CODE_DEFAULT);
    rreg(ADDR_NVM_WRITE_UNLOCK, RDATA_PENDING);
    i_lmc_host_model.fin();
    @(negedge clk_i);
    check(nvm_we, 1, "open");
    rreg(ADDR_NVM_WRITE_UNLOCK, RDATA_PENDING);
    i_lmc_host_model.fin();
    @(negedge clk_i);
    check(nvm_we, 0, "closed");
    rreg(ADDR_NVM_WRITE_UNLOCK, RDATA_ZERO);
    $display("test unlock done");
  endtask
  task automatic t_reset();
    @(negedge clk_i);
    rst_i  = 1'b1;
    pres_i = 1'b1;
    ceil_i = 3'h2;
    repeat (2) @(negedge clk_i);
    check({t_en, i_en, nvm_we, f_en}, 4'h0, "reset outputs");
    rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rreg(ADDR_LED_CONFIGURATION, {5'h10, ceil_i});
    rreg(ADDR_LED_CONTROL, RST_LED_CONTROL);
    check(f_en, 1, "present from memory");
    $display("test reset done");
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    t_regs();
    t_duty();
    t_indicator();
    t_pulse();
    t_unlock();
    t_reset();
    end_of_test();
  end
  initial begin
    #1000000;
    failures++;
    $display("MISMATCH t=%0t timeout", $time);
    end_of_test();
  end
endmodule
